//--- rtl/vpc_params.svh
// Constants for the vertex position clip test block
`ifndef VPC_PARAMS_SVH
`define VPC_PARAMS_SVH
`define VPC_WORD_W 32
`define VPC_SIGN_BIT 31
`define VPC_EXP_MSB 30
`define VPC_EXP_LSB 23
`define VPC_MAN_MSB 22
`define VPC_EXP_ONES 8'hff
`define VPC_EXP_ZERO 8'h00
`define VPC_MAN_ZERO 23'h000000
`define VPC_QNAN 32'h7fc00000
`define VPC_INF_MAG 31'h7f800000
`define VPC_ZERO_MAG 31'h00000000
`define VPC_ONE_MAG 31'h3f800000
`define VPC_HDR_POS_X 4
`define VPC_HDR_POS_Y 5
`define VPC_HDR_POS_Z 6
`define VPC_HDR_RHW 7
`define VPC_FIFO_DEPTH 4
`define VPC_FIFO_AW 2
`endif

//--- rtl/vpc_pkg.sv
// Types and float classifiers shared by both ends
`include "vpc_params.svh"
package vpc_pkg;
    typedef enum logic {
        normalized_space_mode,
        pixel_space_mode
    } vpc_space_t;

    // Header words D4..D7 first, clip-space words held beyond the header
    typedef struct packed {
        logic last;
        logic [`VPC_WORD_W-1:0] clip_w;
        logic [`VPC_WORD_W-1:0] clip_z;
        logic [`VPC_WORD_W-1:0] clip_y;
        logic [`VPC_WORD_W-1:0] clip_x;
        logic [`VPC_WORD_W-1:0] reciprocal_w;
        logic [`VPC_WORD_W-1:0] pos_z;
        logic [`VPC_WORD_W-1:0] pos_y;
        logic [`VPC_WORD_W-1:0] pos_x;
    } vpc_vertex_t;

    function automatic logic vpc_is_nan(input logic [`VPC_WORD_W-1:0] f);
        return (f[`VPC_EXP_MSB:`VPC_EXP_LSB] == `VPC_EXP_ONES) &&
            (f[`VPC_MAN_MSB:0] != `VPC_MAN_ZERO);
    endfunction

    function automatic logic vpc_is_inf(input logic [`VPC_WORD_W-1:0] f);
        return f[`VPC_EXP_MSB:0] == `VPC_INF_MAG;
    endfunction

    // Zero or denormal
    function automatic logic vpc_is_zd(input logic [`VPC_WORD_W-1:0] f);
        return f[`VPC_EXP_MSB:`VPC_EXP_LSB] == `VPC_EXP_ZERO;
    endfunction

    // Component times reciprocal of W, special operands only; hdr for finite cases
    function automatic logic [`VPC_WORD_W-1:0] vpc_ndc_fix(
        input logic [`VPC_WORD_W-1:0] comp,
        input logic [`VPC_WORD_W-1:0] w,
        input logic [`VPC_WORD_W-1:0] hdr);
        logic sgn;
        sgn = comp[`VPC_SIGN_BIT] ^ w[`VPC_SIGN_BIT];
        if (vpc_is_nan(w) || vpc_is_nan(comp)) begin
            return `VPC_QNAN;
        end else if (vpc_is_inf(w) && vpc_is_inf(comp)) begin
            return `VPC_QNAN;
        end else if (vpc_is_zd(w) && vpc_is_zd(comp)) begin
            return `VPC_QNAN;
        end else if (vpc_is_inf(w)) begin
            return {sgn, `VPC_ZERO_MAG};
        end else if (vpc_is_zd(w)) begin
            return {sgn, `VPC_INF_MAG};
        end
        return hdr;
    endfunction

    // Reciprocal of W for special operands; given value otherwise
    function automatic logic [`VPC_WORD_W-1:0] vpc_rhw_fix(
        input logic [`VPC_WORD_W-1:0] w,
        input logic [`VPC_WORD_W-1:0] given);
        if (vpc_is_nan(w)) begin
            return `VPC_QNAN;
        end else if (vpc_is_inf(w)) begin
            return {w[`VPC_SIGN_BIT], `VPC_ZERO_MAG};
        end else if (vpc_is_zd(w)) begin
            return {w[`VPC_SIGN_BIT], `VPC_INF_MAG};
        end
        return given;
    endfunction
endpackage

//--- rtl/vpc_if.sv
// Vertex entry channel between shader threads and the clip stage
`timescale 1ns/10ps
interface vpc_if;
    import vpc_pkg::*;
    logic valid;
    logic ready;
    vpc_vertex_t vtx;
    modport shader (
        output valid,
        output vtx,
        input ready
    );
    modport clip (
        input valid,
        input vtx,
        output ready
    );
endinterface

//--- rtl/vpc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`include "vpc_params.svh"
module vpc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = `VPC_FIFO_DEPTH,
    parameter int AW = `VPC_FIFO_AW
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = count_r != (AW+1)'(DEPTH);
    assign out_valid = count_r != '0;
    assign out_data = mem[rd_ptr_r];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
            rd_ptr_r <= pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
            count_r <= (AW+1)'(count_r + push - pop);
        end
    end
endmodule // vpc_fifo

//--- rtl/vpc_shader_end.sv
// Upstream shader end: performs the speculative division and writes vertex entries
`timescale 1ns/10ps
`include "vpc_params.svh"
module vpc_shader_end
    import vpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire vpc_pkg::vpc_space_t usr_space,
    input wire logic usr_valid,
    output logic usr_ready,
    input wire logic [`VPC_WORD_W-1:0] usr_clip_x,
    input wire logic [`VPC_WORD_W-1:0] usr_clip_y,
    input wire logic [`VPC_WORD_W-1:0] usr_clip_z,
    input wire logic [`VPC_WORD_W-1:0] usr_clip_w,
    input wire logic [`VPC_WORD_W-1:0] usr_pos_x,
    input wire logic [`VPC_WORD_W-1:0] usr_pos_y,
    input wire logic [`VPC_WORD_W-1:0] usr_pos_z,
    input wire logic [`VPC_WORD_W-1:0] usr_rhw,
    input wire logic usr_last,
    vpc_if.shader vif
);
    typedef enum logic {S_IDLE, S_SEND} vpc_sh_state_t;
    vpc_sh_state_t state_r;
    vpc_vertex_t vtx_r;
    vpc_vertex_t vtx_nxt;
    wire ndc = usr_space == normalized_space_mode;
    wire take = usr_valid && usr_ready;

    assign usr_ready = state_r == S_IDLE;
    assign vif.valid = state_r == S_SEND;
    assign vif.vtx = vtx_r;

    // Clip-space position kept beyond the header
    assign vtx_nxt.clip_x = usr_clip_x;
    assign vtx_nxt.clip_y = usr_clip_y;
    assign vtx_nxt.clip_z = usr_clip_z;
    assign vtx_nxt.clip_w = usr_clip_w;
    assign vtx_nxt.last = usr_last;
    // Speculative division for every vertex in normalized mode
    assign vtx_nxt.pos_x = ndc ? vpc_ndc_fix(usr_clip_x, usr_clip_w, usr_pos_x) : usr_pos_x;
    assign vtx_nxt.pos_y = ndc ? vpc_ndc_fix(usr_clip_y, usr_clip_w, usr_pos_y) : usr_pos_y;
    assign vtx_nxt.pos_z = ndc ? vpc_ndc_fix(usr_clip_z, usr_clip_w, usr_pos_z) : usr_pos_z;
    assign vtx_nxt.reciprocal_w = vpc_rhw_fix(usr_clip_w, usr_rhw);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r <= S_IDLE;
            vtx_r <= '0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (take) begin
                        vtx_r <= vtx_nxt;
                        state_r <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (vif.ready) begin
                        state_r <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // vpc_shader_end

//--- rtl/vpc_clip_end.sv
// Clip stage end: vertex bounds check, bad-vertex marking and object rejection
// Overview of operation
// - Space select bit picks header interpretation
// - Bounds check depends on coordinate space
// - NaN reciprocal_w marks vertex bad
// - Object with bad vertex is trivially rejected
// - Setup stage carries no space select bit
// - NDC components equal clip times reciprocal_w
// - NaN W or component gives NaN
// - Inf*inf or zero*zero cases give NaN
// - Infinite W, finite component gives zero
// - Zero W, nonzero component gives infinity
// - Upstream divides every vertex in normalized mode
// - Clip-space kept beyond header, NDC inside
// - Outside vertices use stored clip coordinates in normalized mode, unless this or an earlier vertex of the object is bad
// - Header position words, or clip words on fallback, reach downstream
// - Pixel mode: pixel XY, mapped Z, rhw
// - D4..D6 hold position X, Y, Z
// - D7 holds reciprocal_w
`timescale 1ns/10ps
`include "vpc_params.svh"
module vpc_clip_end
    import vpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire vpc_pkg::vpc_space_t vertex_coord_space_sel,
    input wire logic [`VPC_WORD_W-1:0] vp_max_x,
    input wire logic [`VPC_WORD_W-1:0] vp_max_y,
    vpc_if.clip vif,
    output logic out_valid,
    input wire logic out_ready,
    output logic [`VPC_WORD_W-1:0] out_pos_x,
    output logic [`VPC_WORD_W-1:0] out_pos_y,
    output logic [`VPC_WORD_W-1:0] out_pos_z,
    output logic [`VPC_WORD_W-1:0] out_rhw,
    output logic out_bad,
    output logic out_outside,
    output logic out_use_clip,
    output logic out_last,
    output logic out_reject
);
    typedef enum logic {S_EMPTY, S_FULL} vpc_cl_state_t;
    vpc_cl_state_t state_r;
    vpc_vertex_t fifo_vtx;
    logic fifo_valid;
    logic fifo_ready;

    // Buffering decouples shader bursts from downstream stalls
    vpc_fifo #(
        .WIDTH($bits(vpc_vertex_t)),
        .DEPTH(`VPC_FIFO_DEPTH),
        .AW(`VPC_FIFO_AW)
    ) u_vpc_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .in_valid(vif.valid),
        .in_ready(vif.ready),
        .in_data(vif.vtx),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_vtx)
    );

    // Header interpretation chosen by the state bit
    // Sampled per vertex; a change of space in mid-object is not guarded
    wire ndc = vertex_coord_space_sel == normalized_space_mode;
    wire take = fifo_valid && fifo_ready;

    // Output stage is a one-deep register; accept when it empties this cycle
    // Combinational ready keeps full rate without a skid buffer
    assign fifo_ready = (state_r == S_EMPTY) || out_ready;
    assign out_valid = state_r == S_FULL;

    // Special operands resolved from the clip-space words in normalized mode
    wire [`VPC_WORD_W-1:0] ndc_x;
    wire [`VPC_WORD_W-1:0] ndc_y;
    wire [`VPC_WORD_W-1:0] ndc_z;
    assign ndc_x = vpc_ndc_fix(fifo_vtx.clip_x, fifo_vtx.clip_w, fifo_vtx.pos_x);
    assign ndc_y = vpc_ndc_fix(fifo_vtx.clip_y, fifo_vtx.clip_w, fifo_vtx.pos_y);
    assign ndc_z = vpc_ndc_fix(fifo_vtx.clip_z, fifo_vtx.clip_w, fifo_vtx.pos_z);

    wire [`VPC_WORD_W-1:0] hx;
    wire [`VPC_WORD_W-1:0] hy;
    wire [`VPC_WORD_W-1:0] hz;
    assign hx = ndc ? ndc_x : fifo_vtx.pos_x;
    assign hy = ndc ? ndc_y : fifo_vtx.pos_y;
    assign hz = ndc ? ndc_z : fifo_vtx.pos_z;

    // NaN on the reciprocal_w word
    // Checked in both spaces, since reciprocal_w means the same in each
    wire bad = vpc_is_nan(fifo_vtx.reciprocal_w);

    // Unit cube test is a magnitude compare on the raw float bits
    function automatic logic in_unit(input logic [`VPC_WORD_W-1:0] f);
        return f[`VPC_EXP_MSB:0] <= `VPC_ONE_MAG;
    endfunction

    // Pixel test: non-negative and not past the viewport extent
    function automatic logic in_pix(
        input logic [`VPC_WORD_W-1:0] f,
        input logic [`VPC_WORD_W-1:0] lim);
        return (!f[`VPC_SIGN_BIT] || f[`VPC_EXP_MSB:0] == `VPC_ZERO_MAG) &&
            !vpc_is_nan(f) && (f[`VPC_EXP_MSB:0] <= lim[`VPC_EXP_MSB:0]);
    endfunction

    // Per-axis results kept apart; Z has no pixel bound, it is already depth
    wire unit_x = in_unit(hx);
    wire unit_y = in_unit(hy);
    wire unit_z = in_unit(hz);
    wire pix_x = in_pix(hx, vp_max_x);
    wire pix_y = in_pix(hy, vp_max_y);
    wire inside_ndc = unit_x && unit_y && unit_z;
    wire inside_pix = pix_x && pix_y;
    wire outside = ndc ? !inside_ndc : !inside_pix;

    // Object holds a bad vertex if any earlier one or this one is bad
    logic obj_bad_r;
    logic obj_bad_nxt;
    wire reject = obj_bad_r || bad;

    // Unusable division results on outside vertices give way to clip coordinates
    wire use_clip = ndc && outside && !reject;

    assign obj_bad_nxt = take ? (fifo_vtx.last ? 1'b0 : reject) : obj_bad_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            obj_bad_r <= 1'b0;
        end else begin
            obj_bad_r <= obj_bad_nxt;
        end
    end

    // Stays full while drained and refilled in the same cycle
    vpc_cl_state_t state_nxt;
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_EMPTY: begin
                if (take) begin
                    state_nxt = S_FULL;
                end
            end
            S_FULL: begin
                if (out_ready && !take) begin
                    state_nxt = S_EMPTY;
                end
            end
            default: state_nxt = S_EMPTY;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r <= S_EMPTY;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Next values of the output stage; clip words stand in on fallback
    logic [`VPC_WORD_W-1:0] pos_x_nxt;
    logic [`VPC_WORD_W-1:0] pos_y_nxt;
    logic [`VPC_WORD_W-1:0] pos_z_nxt;
    logic [`VPC_WORD_W-1:0] rhw_nxt;
    logic reject_nxt;
    assign pos_x_nxt = use_clip ? fifo_vtx.clip_x : hx;
    assign pos_y_nxt = use_clip ? fifo_vtx.clip_y : hy;
    assign pos_z_nxt = use_clip ? fifo_vtx.clip_z : hz;
    assign rhw_nxt = use_clip ? fifo_vtx.clip_w : fifo_vtx.reciprocal_w;
    // Rejection is decided once the whole object has been seen
    assign reject_nxt = fifo_vtx.last && reject;

    // Header words, or clip words on fallback, leave; no space bit follows them downstream
    always_ff @(posedge core_clk) begin
        if (reset) begin
            out_pos_x <= '0;
            out_pos_y <= '0;
            out_pos_z <= '0;
            out_rhw <= '0;
        end else if (take) begin
            out_pos_x <= pos_x_nxt;
            out_pos_y <= pos_y_nxt;
            out_pos_z <= pos_z_nxt;
            out_rhw <= rhw_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            out_bad <= 1'b0;
            out_outside <= 1'b0;
            out_use_clip <= 1'b0;
            out_last <= 1'b0;
            out_reject <= 1'b0;
        end else if (take) begin
            out_bad <= bad;
            out_outside <= outside;
            out_use_clip <= use_clip;
            out_last <= fifo_vtx.last;
            out_reject <= reject_nxt;
        end
    end

    // Setup stage takes positions as given; its viewport mapping is software's
    // choice, and this stage sends it nothing that selects a space
endmodule // vpc_clip_end

//--- verif/vpc_link_chk.sv
// Checker on the vertex channel between the two ends
`timescale 1ns/10ps
module vpc_link_chk
    import vpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic valid,
    input wire logic ready,
    input wire vpc_pkg::vpc_vertex_t vtx
);
    wire logic [31:0] w = vtx.clip_w;
    wire logic [31:0] r = vtx.reciprocal_w;
    wire logic w_nan = (w[30:23] == 8'hff) && (w[22:0] != 23'h0);
    wire logic w_inf = (w[30:0] == 31'h7f800000);
    wire logic w_zd = (w[30:23] == 8'h00);
    wire logic r_nan = (r[30:23] == 8'hff) && (r[22:0] != 23'h0);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence s_offer;
        valid && !ready;
    endsequence
    sequence s_take;
        valid && ready;
    endsequence

    property p_hold_valid;
        s_offer |=> valid;
    endproperty
    a_hold_valid: assert property (p_hold_valid)
        else $error("offer withdrawn before ready");
    property p_hold_vtx;
        s_offer |=> $stable(vtx);
    endproperty
    a_hold_vtx: assert property (p_hold_vtx)
        else $error("vertex changed while offered");
    property p_gap;
        s_take |=> !valid;
    endproperty
    a_gap: assert property (p_gap)
        else $error("offer repeated right after a take");
    property p_wake;
        $fell(reset) |-> ready && !valid;
    endproperty
    a_wake: assert property (p_wake)
        else $error("channel not idle after reset");
    // Quiet NaN is the one pattern the shader end produces
    property p_rhw_nan;
        valid && w_nan |-> r == 32'h7fc00000;
    endproperty
    a_rhw_nan: assert property (p_rhw_nan)
        else $error("rhw not NaN for NaN w");
    property p_rhw_inf;
        valid && w_inf |-> r == {w[31], 31'h0};
    endproperty
    a_rhw_inf: assert property (p_rhw_inf)
        else $error("rhw not signed zero for infinite w");
    property p_rhw_zd;
        valid && w_zd |-> r == {w[31], 31'h7f800000};
    endproperty
    a_rhw_zd: assert property (p_rhw_zd)
        else $error("rhw not signed infinity for zero w");
    property p_rhw_quiet;
        valid && !w_nan |-> !r_nan;
    endproperty
    a_rhw_quiet: assert property (p_rhw_quiet)
        else $error("rhw NaN for a non NaN w");
endmodule // vpc_link_chk

//--- verif/tb_vertex_position_clip_test.sv
// Bench joining the shader end and the clip end through the vertex channel
`timescale 1ns/10ps
module tb_vertex_position_clip_test;
    import vpc_pkg::*;
    localparam logic [31:0] A = 32'h3f000000;
    localparam logic [31:0] ONE = 32'h3f800000;
    localparam logic [31:0] NEG1 = 32'hbf800000;
    localparam logic [31:0] TWO = 32'h40000000;
    localparam logic [31:0] QN = 32'h7fc00000;
    localparam logic [31:0] PI = 32'h7f800000;
    localparam logic [31:0] NI = 32'hff800000;
    localparam logic [31:0] NZ = 32'h80000000;
    localparam logic [31:0] WN = 32'h7f800001;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    vpc_space_t space = normalized_space_mode;
    logic uv = 1'b0;
    logic ul = 1'b0;
    logic ordy = 1'b1;
    logic [31:0] cx = 32'h0;
    logic [31:0] cy = 32'h0;
    logic [31:0] cz = 32'h0;
    logic [31:0] cw = 32'h0;
    logic [31:0] px = 32'h0;
    logic [31:0] vmax = 32'h44000000;
    wire ur;
    wire ov;
    wire [31:0] ox, oy, oz, ow;
    wire ob, oo, ou, ol, orj;
    logic [132:0] q[$];
    int n_mismatch = 0;
    int comparisons = 0;

    vpc_if u_vpc_if();
    vpc_shader_end u_vpc_shader_end (
        .core_clk(core_clk), .reset(reset), .usr_space(space), .usr_valid(uv),
        .usr_ready(ur), .usr_clip_x(cx), .usr_clip_y(cy), .usr_clip_z(cz),
        .usr_clip_w(cw), .usr_pos_x(px), .usr_pos_y(A), .usr_pos_z(A), .usr_rhw(A),
        .usr_last(ul), .vif(u_vpc_if.shader)
    );
    vpc_clip_end u_vpc_clip_end (
        .core_clk(core_clk), .reset(reset), .vertex_coord_space_sel(space),
        .vp_max_x(vmax), .vp_max_y(vmax), .vif(u_vpc_if.clip), .out_valid(ov),
        .out_ready(ordy), .out_pos_x(ox), .out_pos_y(oy), .out_pos_z(oz), .out_rhw(ow),
        .out_bad(ob), .out_outside(oo), .out_use_clip(ou), .out_last(ol), .out_reject(orj)
    );
    vpc_link_chk u_vpc_link_chk (
        .core_clk(core_clk), .reset(reset), .valid(u_vpc_if.valid),
        .ready(u_vpc_if.ready), .vtx(u_vpc_if.vtx)
    );

    always #2.5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (!reset && ov && ordy) begin
            q.push_back({ox, oy, oz, ow, ob, oo, ou, ol, orj});
        end
    end

    // Offer held from a falling edge until the falling edge after the rising edge that takes it
    task automatic put(input logic [31:0] w, x, y, z, p, input logic lst);
        int n;
        @(negedge core_clk);
        cw = w;
        cx = x;
        cy = y;
        cz = z;
        px = p;
        ul = lst;
        uv = 1'b1;
        n = 0;
        while (ur !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        uv = 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, y, z, w, input logic [4:0] f);
        logic [132:0] e;
        logic [132:0] g;
        int n;
        e = {x, y, z, w, f};
        g = 'x;
        n = 0;
        while (q.size() == 0 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        if (q.size() > 0) begin
            g = q.pop_front();
        end
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Whole run needs about a hundred cycles; fifty times that means a hang
    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        summarize();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        put(TWO, ONE, ONE, ONE, A, 1'b1);
        chk("inside", A, A, A, A, 5'b00010);
        put(TWO, 32'h40800000, ONE, ONE, TWO, 1'b1);
        chk("fallback", 32'h40800000, ONE, ONE, TWO, 5'b01110);
        $display("test basic done");
        // Bad first vertex keeps later outside vertices on header words
        put(WN, ONE, ONE, ONE, A, 1'b0);
        chk("nan_w", QN, QN, QN, QN, 5'b11000);
        put(PI, PI, NEG1, ONE, A, 1'b0);
        chk("inf_w", QN, NZ, 32'h0, 32'h0, 5'b01000);
        put(32'h80000001, 32'h00000002, ONE, NEG1, A, 1'b0);
        chk("zero_w", QN, NI, PI, NI, 5'b01000);
        put(NI, ONE, NEG1, TWO, A, 1'b1);
        chk("far_w", NZ, 32'h0, NZ, NZ, 5'b00011);
        put(TWO, ONE, ONE, ONE, A, 1'b1);
        chk("cleared", A, A, A, A, 5'b00010);
        $display("test special done");
        space = pixel_space_mode;
        put(TWO, ONE, ONE, ONE, 32'h43000000, 1'b1);
        chk("pix_in", 32'h43000000, A, A, A, 5'b00010);
        put(TWO, ONE, ONE, ONE, 32'h44800000, 1'b1);
        chk("pix_far", 32'h44800000, A, A, A, 5'b01010);
        put(WN, ONE, ONE, ONE, 32'hc3000000, 1'b1);
        chk("pix_bad", 32'hc3000000, A, A, QN, 5'b11011);
        $display("test pixel done");
        // Stalled sink: output stage and four entries fill, the sixth waits
        ordy = 1'b0;
        fork
            for (int i = 0; i < 6; i++) begin
                put(TWO, ONE, ONE, ONE, {28'h4300000, i[3:0]}, 1'b1);
            end
        join_none
        repeat (40) @(negedge core_clk);
        comparisons++;
        if (u_vpc_if.ready !== 1'b0 || ur !== 1'b0) begin
            n_mismatch++;
            $display("[FAIL] ready expected 0 seen %b", u_vpc_if.ready);
        end
        ordy = 1'b1;
        for (int i = 0; i < 6; i++) begin
            chk("fill", {28'h4300000, i[3:0]}, A, A, A, 5'b00010);
        end
        $display("test fill done");
        summarize();
    end
endmodule // tb_vertex_position_clip_test
